// [dhp_drive_model.sv]
`timescale 1ns/1ps
module dhp_drive_model (
  // Clock
  input wire logic        aclk,
  // Head motion
  input wire logic [3:0]  step,
  input wire logic [3:0]  direction,
  // Drive status
  output     logic [3:0]  track_zero_input,
  output     logic [31:0] head_cyl
);
  logic [3:0]  step_q = 4'h0;
  logic [31:0] pos    = 32'h0000_0000;

  // Heads move on the rising step edge
  always_ff @(posedge aclk) begin
    step_q <= step;
    for (int i = 0; i < 4; i++) begin
      if (step[i] && !step_q[i]) begin
        if (direction[i]) pos[8*i +: 8] <= pos[8*i +: 8] + 8'h01;
        else if (pos[8*i +: 8] != 8'h00) pos[8*i +: 8] <= pos[8*i +: 8] - 8'h01;
      end
    end
  end
  always_comb begin
    for (int j = 0; j < 4; j++) track_zero_input[j] = (pos[8*j +: 8] == 8'h00);
  end
  assign head_cyl = pos;
endmodule

// [dhp_pkg.sv]
package dhp_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CMD        = 8'h00;
  localparam logic [7:0] ADDR_STEP_RATE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_SENSE      = 8'h0C;
  localparam logic [7:0] ADDR_ID_FIELD   = 8'h10;
  localparam logic [7:0] ADDR_POWER      = 8'h14;
  localparam logic [7:0] ADDR_PCYL_BASE  = 8'h20;
  localparam logic [7:0] ADDR_FMT_GAP    = 8'h30;
  localparam logic [7:0] ADDR_GAP_LEN    = 8'h34;

  // Command register fields
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_DRV_LSB    = 4;
  localparam int CMD_TARGET_LSB = 8;

  // Command opcodes
  localparam logic [3:0] OP_IDENTIFY = 4'h1;
  localparam logic [3:0] OP_TRACK0   = 4'h2;
  localparam logic [3:0] OP_SEEK     = 4'h3;
  localparam logic [3:0] OP_NOP      = 4'h4;

  // Interrupt codes
  localparam logic [1:0] IC_NORMAL   = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL     = 2'h3;

  // Reset values
  localparam logic [3:0] STEP_RATE_RESET = 4'h0;
  localparam logic [7:0] GAP_LEN_RESET   = 8'h1B;

  // Track-zero retry limit
  localparam logic [6:0] TRACK0_MAX_STEPS = 7'd79;

  // Single-density format layout
  localparam logic [7:0] SD_GAP_INDEX = 8'd40;
  localparam logic [7:0] SD_GAP_ID    = 8'd26;
  localparam logic [7:0] SD_GAP_DATA  = 8'd11;
  localparam logic [7:0] SD_SYNC_LEN  = 8'd6;
  localparam logic [7:0] SD_GAP_BYTE  = 8'hFF;
  localparam logic [7:0] SD_SYNC_BYTE = 8'h00;

  // Timing: step pulse width and step interval unit
  localparam int CLK_MHZ        = 50;
  localparam int STEP_PULSE_US  = 1;
  localparam int STEP_UNIT_US   = 500;
  localparam int STEP_PULSE_CYC = STEP_PULSE_US * CLK_MHZ;
  localparam int STEP_UNIT_CYC  = STEP_UNIT_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } dhp_id_t;

  typedef struct packed {
    logic       seek_end_flag;
    logic       equipment_check_flag;
    logic [1:0] interrupt_code;
  } dhp_sense_t;

endpackage

// [dhp_stepper.sv]
`timescale 1ns/1ps
module dhp_stepper (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Control
  input  wire logic                   start_seek,
  input  wire logic                   start_track0,
  input  wire logic [7:0]             target_cylinder,
  input  wire logic [3:0]             step_rate_time,
  input  wire logic                   clear_cyl,
  input  wire logic                   track_zero,
  // Status
  output      logic [7:0]             present_cylinder,
  output      logic                   step,
  output      logic                   direction,
  output      logic                   done,
  output      dhp_pkg::dhp_sense_t    sense
);
  import dhp_pkg::*;

  typedef enum {ST_IDLE, ST_CHECK, ST_PULSE, ST_WAIT} dhp_step_st_t;
  dhp_step_st_t state;
  logic         recal;
  logic [6:0]   steps;
  logic [23:0]  timer;

  // Interval shrinks as the programmed code rises
  function automatic logic [23:0] interval(input logic [3:0] code);
    interval = 24'((16 - int'(code)) * STEP_UNIT_CYC);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      recal <= 1'b0;
      steps <= 7'd0;
      timer <= 24'd0;
      step <= 1'b0;
      direction <= 1'b0;
      done <= 1'b0;
      sense <= '0;
      present_cylinder <= 8'd0;
    end else begin
      done <= 1'b0;
      if (clear_cyl) begin
        present_cylinder <= 8'd0;
        sense <= '0;
        state <= ST_IDLE;
        step <= 1'b0;
      end else unique case (state)
        ST_IDLE: begin
          if (start_track0) begin
            present_cylinder <= 8'd0;
            recal <= 1'b1;
            steps <= 7'd0;
            state <= ST_CHECK;
          end else if (start_seek) begin
            recal <= 1'b0;
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (recal) begin
            if (track_zero) begin
              sense <= '{1'b1, 1'b0, IC_NORMAL};
              done <= 1'b1;
              state <= ST_IDLE;
            end else if (steps == TRACK0_MAX_STEPS) begin
              sense <= '{1'b1, 1'b1, IC_ABNORMAL};
              done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              direction <= 1'b0;
              step <= 1'b1;
              steps <= steps + 7'd1;
              timer <= 24'(STEP_PULSE_CYC);
              state <= ST_PULSE;
            end
          end else if (present_cylinder == target_cylinder) begin
            sense <= '{1'b1, 1'b0, IC_NORMAL};
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            direction <= present_cylinder < target_cylinder;
            step <= 1'b1;
            timer <= 24'(STEP_PULSE_CYC);
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (timer <= 24'd1) begin
            step <= 1'b0;
            if (!recal)
              present_cylinder <= direction ? present_cylinder + 8'd1 : present_cylinder - 8'd1;
            timer <= interval(step_rate_time);
            state <= ST_WAIT;
          end else begin
            timer <= timer - 24'd1;
          end
        end
        ST_WAIT: begin
          if (timer <= 24'd1)
            state <= ST_CHECK;
          else
            timer <= timer - 24'd1;
        end
      endcase
    end
  end

endmodule

// [dhp_top.sv]
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dhp_top (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output      logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output      logic          s_axi_wready,
  output      logic [1:0]    s_axi_bresp,
  output      logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output      logic          s_axi_arready,
  output      logic [31:0]   s_axi_rdata,
  output      logic [1:0]    s_axi_rresp,
  output      logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Drive interface
  output      logic [3:0]    step,
  output      logic [3:0]    direction,
  input  wire logic [3:0]    track_zero_input,
  input  wire logic          index_pulse_input,
  // Identification field from the read channel
  input  wire logic          id_mark_found,
  input  wire dhp_pkg::dhp_id_t id_field,
  input  wire logic          id_crc_ok,
  // Controller interrupt
  output      logic          irq
);
  import dhp_pkg::*;

  // Pin synchronisers
  logic [3:0] tz_meta;
  logic [3:0] tz_sync;
  logic       idx_meta;
  logic       idx_sync;
  logic       idx_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tz_meta <= 4'h0;
      tz_sync <= 4'h0;
      idx_meta <= 1'b0;
      idx_sync <= 1'b0;
      idx_prev <= 1'b0;
    end else begin
      tz_meta <= track_zero_input;
      tz_sync <= tz_meta;
      idx_meta <= index_pulse_input;
      idx_sync <= idx_meta;
      idx_prev <= idx_sync;
    end
  end
  logic idx_rise;
  assign idx_rise = idx_sync & ~idx_prev;

  // AXI write path
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_addr(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == ADDR_CMD) || (a == ADDR_STEP_RATE) || (a == ADDR_STATUS) ||
                 (a == ADDR_SENSE) || (a == ADDR_ID_FIELD) || (a == ADDR_POWER) ||
                 (a == ADDR_FMT_GAP) || (a == ADDR_GAP_LEN) ||
                 (a[7:4] == ADDR_PCYL_BASE[7:4] && a[1:0] == 2'b00);
  endfunction

  // Register writes
  logic [3:0] step_rate_time;
  logic [7:0] gap_length;
  logic       low_power;
  logic       cmd_wr;
  logic       wake;
  logic [3:0] cmd_op;
  logic [1:0] cmd_drv;
  logic [7:0] cmd_target;
  assign cmd_wr = wr_fire && aw_addr == ADDR_CMD && w_strb[0];
  assign cmd_op = w_data[CMD_OP_LSB +: 4];
  assign cmd_drv = w_data[CMD_DRV_LSB +: 2];
  assign cmd_target = w_data[CMD_TARGET_LSB +: 8];
  assign wake = wr_fire && aw_addr == ADDR_POWER && w_strb[0] && low_power && !w_data[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_rate_time <= STEP_RATE_RESET;
      gap_length <= GAP_LEN_RESET;
      low_power <= 1'b0;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == ADDR_STEP_RATE)
        step_rate_time <= w_data[3:0];
      if (aw_addr == ADDR_GAP_LEN)
        gap_length <= w_data[7:0];
      if (aw_addr == ADDR_POWER)
        low_power <= w_data[0];
    end
  end

  // Per-drive sequencers
  logic [3:0]       drv_busy_n;
  logic [3:0]       drv_done;
  logic [3:0][7:0]  pcyl;
  dhp_sense_t [3:0] drv_sense;
  logic [3:0][7:0]  tcyl;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_drv
      logic go_seek;
      logic go_t0;
      assign go_seek = cmd_wr && !low_power && cmd_drv == 2'(g) && cmd_op == OP_SEEK;
      assign go_t0   = cmd_wr && !low_power && cmd_drv == 2'(g) && cmd_op == OP_TRACK0;
      always_ff @(posedge aclk) begin
        if (!aresetn)
          tcyl[g] <= 8'h00;
        else if (go_seek)
          tcyl[g] <= cmd_target;
      end
      dhp_stepper u_step (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .start_seek       (go_seek),
        .start_track0     (go_t0),
        .target_cylinder  (go_seek ? cmd_target : tcyl[g]),
        .step_rate_time   (step_rate_time),
        .clear_cyl        (wake),
        .track_zero       (tz_sync[g]),
        .present_cylinder (pcyl[g]),
        .step             (step[g]),
        .direction        (direction[g]),
        .done             (drv_done[g]),
        .sense            (drv_sense[g])
      );
    end
  endgenerate

  // Identify-position sequencer and held status
  typedef enum {ID_IDLE, ID_SEARCH} dhp_id_st_t;
  dhp_id_st_t id_state;
  logic [1:0] idx_count;
  dhp_id_t    id_reg;
  logic       id_done;
  logic [1:0] id_ic;
  logic       missing_mark_flag;
  logic [1:0] id_drv;
  always_ff @(posedge aclk) begin
    if (!aresetn || wake) begin
      id_state <= ID_IDLE;
      idx_count <= 2'd0;
      id_reg <= '0;
      id_done <= 1'b0;
      id_ic <= IC_NORMAL;
      missing_mark_flag <= 1'b0;
      id_drv <= 2'd0;
    end else begin
      id_done <= 1'b0;
      unique case (id_state)
        ID_IDLE: begin
          if (cmd_wr && !low_power && cmd_op == OP_IDENTIFY) begin
            id_state <= ID_SEARCH;
            idx_count <= 2'd0;
            id_drv <= cmd_drv;
            missing_mark_flag <= 1'b0;
          end
        end
        ID_SEARCH: begin
          if (id_mark_found && id_crc_ok) begin
            id_reg <= id_field;
            id_ic <= IC_NORMAL;
            id_done <= 1'b1;
            id_state <= ID_IDLE;
          end else if (idx_rise) begin
            if (idx_count == 2'd1) begin
              id_ic <= IC_ABNORMAL;
              missing_mark_flag <= 1'b1;
              id_done <= 1'b1;
              id_state <= ID_IDLE;
            end else begin
              idx_count <= idx_count + 2'd1;
            end
          end
        end
      endcase
    end
  end

  // Busy only while a command is being taken or identify runs
  logic busy;
  assign busy = cmd_wr || id_state == ID_SEARCH;

  // Pending completions and interrupt-status reporting
  logic [3:0] pend;
  logic       id_pend;
  logic       sense_rd;
  logic [7:0] sense_word;
  logic [1:0] sense_drv;
  always_comb begin
    sense_drv = 2'd0;
    for (int i = 3; i >= 0; i--)
      if (pend[i])
        sense_drv = 2'(i);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || wake) begin
      pend <= 4'h0;
      id_pend <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++)
        if (drv_done[i])
          pend[i] <= 1'b1;
        else if (sense_rd && |pend && sense_drv == 2'(i))
          pend[i] <= 1'b0;
      if (id_done)
        id_pend <= 1'b1;
      else if (sense_rd && !(|pend))
        id_pend <= 1'b0;
    end
  end
  assign irq = |pend || id_pend;

  // Status byte: seek-end, equip check, head bit 0, drive
  always_comb begin
    if (|pend)
      sense_word = {drv_sense[sense_drv].interrupt_code, drv_sense[sense_drv].seek_end_flag,
                    drv_sense[sense_drv].equipment_check_flag, 1'b0, 1'b0, sense_drv};
    else if (id_pend)
      sense_word = {id_ic, 1'b0, 1'b0, 1'b0, 1'b0, id_drv};
    else
      sense_word = {IC_POLL, 1'b0, 1'b0, 4'h0};
  end

  // AXI read path
  logic [31:0] rd_mux;
  assign s_axi_arready = !s_axi_rvalid;
  assign sense_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_SENSE;
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      ADDR_STEP_RATE: rd_mux = {28'h0, step_rate_time};
      ADDR_STATUS:    rd_mux = {26'h0, missing_mark_flag, id_pend, low_power, busy, irq, 1'b0};
      ADDR_SENSE:     rd_mux = {16'h0, pcyl[sense_drv], sense_word};
      ADDR_ID_FIELD:  rd_mux = id_reg;
      ADDR_POWER:     rd_mux = {31'h0, low_power};
      ADDR_FMT_GAP:   rd_mux = {SD_SYNC_BYTE, SD_GAP_DATA, SD_GAP_ID, SD_GAP_INDEX};
      ADDR_GAP_LEN:   rd_mux = {SD_GAP_BYTE, SD_SYNC_LEN, 8'h00, gap_length};
      default: begin
        if (s_axi_araddr[7:4] == ADDR_PCYL_BASE[7:4])
          rd_mux = {24'h0, pcyl[s_axi_araddr[3:2]]};
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= known_addr(s_axi_araddr) && s_axi_araddr != ADDR_CMD ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [dhp_top_sva.sv]
`timescale 1ns/1ps
module dhp_top_sva
  import dhp_pkg::*;
(
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Register bus
  input wire logic [7:0]       s_axi_awaddr,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic [31:0]      s_axi_wdata,
  input wire logic [3:0]       s_axi_wstrb,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // Drive side
  input wire logic [3:0]       step,
  input wire logic [3:0]       direction,
  input wire logic [3:0]       track_zero_input,
  input wire logic             index_pulse_input,
  input wire logic             id_mark_found,
  input wire dhp_pkg::dhp_id_t id_field,
  input wire logic             id_crc_ok,
  input wire logic             irq
);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [7:0]  rd_addr;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pulse width and gap of drive 0 steps
  always_ff @(posedge aclk) begin
    if (!aresetn) hi_cnt <= 16'h0000;
    else hi_cnt <= step[0] ? hi_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) lo_cnt <= 16'hFFFF;
    else if (step[0]) lo_cnt <= 16'h0000;
    else if (lo_cnt != 16'hFFFF) lo_cnt <= lo_cnt + 16'h0001;
  end
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end

  chk_step_width: assert property ($fell(step[0]) |-> hi_cnt == STEP_PULSE_CYC)
    else $error("step pulse width wrong");
  chk_step_space: assert property ($rose(step[0]) |-> lo_cnt >= 16'd24999)
    else $error("step pulses too close");
  chk_dir_hold: assert property (step[0] && $past(step[0]) |-> $stable(direction[0]))
    else $error("direction moved during step");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_head_zero: assert property (s_axi_rvalid && rd_addr == ADDR_SENSE |-> s_axi_rdata[2] == 1'b0)
    else $error("head bit not zero");
  chk_sense_code: assert property (s_axi_rvalid && rd_addr == ADDR_SENSE
    |-> ((s_axi_rdata[7:6] == IC_POLL) ? !s_axi_rdata[5] : (s_axi_rdata[7:6] != 2'h2))
        && (!s_axi_rdata[4] || s_axi_rdata[7:5] == {IC_ABNORMAL, 1'b1}))
    else $error("seek end and code disagree");
  chk_gap_fixed: assert property (s_axi_rvalid && rd_addr == ADDR_GAP_LEN
    |-> s_axi_rdata[31:16] == {SD_GAP_BYTE, SD_SYNC_LEN})
    else $error("gap fill fields wrong");
  chk_unmapped: assert property (s_axi_rvalid && rd_addr > ADDR_GAP_LEN |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  cover property ($rose(step[0]));
  cover property ($rose(irq));
  cover property (s_axi_rvalid && rd_addr == ADDR_SENSE && s_axi_rdata[7:6] == IC_NORMAL);
endmodule

bind dhp_top dhp_top_sva u_sva (.*);

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import dhp_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'h0;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rs;
  logic [31:0]      s_axi_rdata, rd, head_cyl;
  logic [3:0]       step, direction, track_zero_input;
  logic             index_pulse_input = 1'b0, id_mark_found = 1'b0, id_crc_ok = 1'b0;
  dhp_id_t          id_field = '0;
  int               bad_count = 0;
  int               check_count = 0;

  dhp_top DUT (.*);
  dhp_drive_model u_drives (.aclk(aclk), .step(step), .direction(direction),
                            .track_zero_input(track_zero_input), .head_cyl(head_cyl));

  always #10 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [1:0] drv, input logic [7:0] tgt);
    wr(ADDR_CMD, {16'h0000, tgt, 2'b00, drv, op});
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 60000) begin
      @(posedge aclk);
      n++;
    end
    chk("irq_raised", 32'h1, {31'h0, irq});
  endtask

  task automatic sense(input logic [1:0] drv, input logic [7:0] cyl, input logic [1:0] code);
    rd_reg(ADDR_SENSE);
    chk("sense", {16'h0, cyl, code, 1'b1, 1'b0, 2'b00, drv}, {16'h0, rd[15:0]});
  endtask

  task automatic id_pulse(input logic ok, input logic [31:0] f);
    @(posedge aclk);
    id_mark_found <= 1'b1;
    id_crc_ok <= ok;
    id_field <= f;
    @(posedge aclk);
    id_mark_found <= 1'b0;
    id_crc_ok <= 1'b0;
  endtask

  task automatic idx_pulse();
    @(posedge aclk);
    index_pulse_input <= 1'b1;
    repeat (10) @(posedge aclk);
    index_pulse_input <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    $display("Error watchdog expected done seen timeout");
    finish_test();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(ADDR_GAP_LEN);
    chk("gap_len", {SD_GAP_BYTE, SD_SYNC_LEN, 8'h00, GAP_LEN_RESET}, rd);
    wr(ADDR_GAP_LEN, 32'h0000_0054);
    rd_reg(ADDR_GAP_LEN);
    chk("gap_len_wr", {SD_GAP_BYTE, SD_SYNC_LEN, 8'h00, 8'h54}, rd);
    rd_reg(ADDR_STEP_RATE);
    chk("step_rate", {28'h0, STEP_RATE_RESET}, rd);
    rd_reg(8'h3C);
    chk("unmapped", 32'h2, {30'h0, rs});
    wr(ADDR_STEP_RATE, 32'h0000_000F);
    $display("test registers done");
    for (int i = 0; i < 4; i++) cmd(OP_TRACK0, i[1:0], 8'h00);
    wait_irq();
    repeat (20) @(posedge aclk);
    for (int i = 0; i < 4; i++) sense(i[1:0], 8'h00, IC_NORMAL);
    $display("test initial recalibration done");
    cmd(OP_NOP, 2'd0, 8'h00);
    repeat (100) @(posedge aclk);
    chk("nop_irq", 32'h0, {31'h0, irq});
    rd_reg(ADDR_SENSE);
    chk("poll", {29'h0, IC_POLL, 1'b0}, {29'h0, rd[7:5]});
    $display("test idle command done");
    cmd(OP_IDENTIFY, 2'd0, 8'h00);
    rd_reg(ADDR_STATUS);
    chk("busy_identify", 32'h1, {31'h0, rd[2]});
    id_pulse(1'b0, 32'h0908_0706);
    id_pulse(1'b1, 32'h0102_0302);
    id_pulse(1'b1, 32'h0504_0302);
    wait_irq();
    rd_reg(ADDR_ID_FIELD);
    chk("id_field", 32'h0102_0302, rd);
    rd_reg(ADDR_SENSE);
    chk("id_code", {30'h0, IC_NORMAL}, {30'h0, rd[7:6]});
    cmd(OP_IDENTIFY, 2'd0, 8'h00);
    repeat (2) idx_pulse();
    wait_irq();
    rd_reg(ADDR_STATUS);
    chk("missing_mark", 32'h1, {31'h0, rd[5]});
    rd_reg(ADDR_SENSE);
    chk("id_abnormal", {30'h0, IC_ABNORMAL}, {30'h0, rd[7:6]});
    $display("test identify done");
    cmd(OP_SEEK, 2'd0, 8'h01);
    cmd(OP_SEEK, 2'd1, 8'h02);
    rd_reg(ADDR_STATUS);
    chk("busy_irq", 32'h0, {30'h0, rd[2:1]});
    wait_irq();
    sense(2'd0, 8'h01, IC_NORMAL);
    wait_irq();
    sense(2'd1, 8'h02, IC_NORMAL);
    chk("heads_in", 32'h0000_0201, head_cyl);
    cmd(OP_IDENTIFY, 2'd1, 8'h00);
    id_pulse(1'b1, 32'h0200_0102);
    wait_irq();
    rd_reg(ADDR_ID_FIELD);
    chk("id_after_seek", 32'h0200_0102, rd);
    rd_reg(ADDR_SENSE);
    chk("id_sense", {24'h0, IC_NORMAL, 4'h0, 2'd1}, {24'h0, rd[7:0]});
    $display("test parallel seek done");
    cmd(OP_TRACK0, 2'd0, 8'h00);
    rd_reg(ADDR_PCYL_BASE);
    chk("pcyl_clear", 32'h0, rd);
    cmd(OP_SEEK, 2'd1, 8'h01);
    wait_irq();
    repeat (200) @(posedge aclk);
    sense(2'd0, 8'h00, IC_NORMAL);
    sense(2'd1, 8'h01, IC_NORMAL);
    chk("heads_out", 32'h0000_0100, head_cyl);
    $display("test outward motion done");
    wr(ADDR_POWER, 32'h0000_0001);
    wr(ADDR_POWER, 32'h0000_0000);
    rd_reg(ADDR_PCYL_BASE + 8'h04);
    chk("pcyl_power", 32'h0, rd);
    $display("test low power done");
    finish_test();
  end
endmodule
